/* tb/bfs_pack_model.sv */
`default_nettype none
module bfs_pack_model (
    input wire logic pclk, // clock
    input wire logic ld_current_en, // load-detect source on
    input wire logic load_removed, // pack pulled out of the system
    input wire logic [15:0] open_mv, // pin level reached with no load
    output logic [15:0] ld_mv // measured load_detect_pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // A present load clamps the pin low whatever the source does
    always_ff @(posedge pclk) begin
        ld_mv <= (ld_current_en && load_removed) ? open_mv : 16'h0320;
    end
endmodule // bfs_pack_model
`default_nettype wire

/* tb/testbench.sv */
`include "bfs_regs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bfs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic otp_done, rs_pin, cblk, dblk, scd, ocd, pf, ld_open;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cell_mv, open_mv, ld_mv;
    bfs_meas_t meas;
    bfs_fets_t fets;
    logic ld_current_en, fault_flag, ldo_en, prereg_en, pd_weak, pd_strong;
    logic swl_sel, vref_b_path, shutdown, boot_done;
    logic [2:0] ldo_sel;
    logic [4:0] mux_sel;
    int fail_count = 0;
    int samples_checked = 0;
    int n, k;
    assign meas = '{cell_mv, ld_mv, scd, ocd, pf, 1'b0};
    bfs_ctrl #(.SHUT_HOLD_CYC(100), .OTP_CYC(8), .TICK_CYC(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas(meas), .reset_shutdown_pin(rs_pin), .charge_block_pin(cblk),
        .discharge_block_pin(dblk), .otp_done(otp_done), .fets(fets),
        .ld_current_en(ld_current_en), .fault_flag(fault_flag), .ldo_en(ldo_en),
        .prereg_en(prereg_en), .ldo_sel(ldo_sel), .pd_weak(pd_weak), .pd_strong(pd_strong),
        .swl_sel(swl_sel), .mux_sel(mux_sel), .vref_b_path(vref_b_path),
        .shutdown(shutdown), .boot_done(boot_done));
    bfs_pack_model pack (.pclk(pclk), .ld_current_en(ld_current_en),
        .load_removed(ld_open), .open_mv(open_mv), .ld_mv(ld_mv));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the write settle before the caller looks at outputs
        @(negedge pclk);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge pclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_boot;
        chk("ldo", {ldo_en, prereg_en, ldo_sel}, 5'h1b);
        chk("link", 1'b0, swl_sel);
        apb(1'b1, `BFS_LDO_ADDR, 32'h0);
        apb(1'b0, `BFS_LDO_ADDR, 32'h0);
        chk("early write", `BFS_LDO_RST, rd);
        @(posedge pclk);
        otp_done <= 1'b1;
        for (n = 0; n < 40 && boot_done !== 1'b1; n++) cyc(1);
        chk("boot", 1'b1, boot_done);
        apb(1'b0, `BFS_THR_ADDR, 32'h0);
        chk("thr", `BFS_THR_RST, rd);
        apb(1'b0, 12'h01c, 32'h0);
        chk("unmapped", 1'b1, err);
    endtask
    task automatic t_ldo;
        for (k = 0; k < 5; k++) begin
            apb(1'b1, `BFS_LDO_ADDR, (k << 2) | 3);
            chk("sel", k[2:0], ldo_sel);
        end
        apb(1'b1, `BFS_LDO_ADDR, 32'h00000017);
        chk("sel5", 3'h4, ldo_sel);
        apb(1'b1, `BFS_LDO_ADDR, 32'h0000000e);
        cyc(1);
        chk("pd", {ldo_en, pd_weak, pd_strong}, 3'h1);
        apb(1'b1, `BFS_LDO_ADDR, `BFS_LDO_RST);
    endtask
    task automatic t_mux;
        for (k = 0; k < 13; k++) begin
            apb(1'b1, `BFS_MUX_ADDR, k);
            chk("mux", (k > 11) ? 5'h0b : k[4:0], mux_sel);
            cyc(1);
            chk("vref", (k >= 6 && k <= 8), vref_b_path);
        end
    endtask
    task automatic t_prechg;
        @(posedge pclk);
        cell_mv <= 16'h07d0;
        apb(1'b1, `BFS_CTRL_ADDR, 32'h10);
        cyc(20);
        chk("precharge_fet", {fets.charge_fet, fets.precharge_fet}, 2'h1);
        @(posedge pclk);
        cell_mv <= 16'h0bb8;
        cyc(20);
        chk("precharge_fet hold", {fets.charge_fet, fets.precharge_fet}, 2'h1);
        @(posedge pclk);
        cell_mv <= 16'h0dac;
        cyc(20);
        chk("chg", {fets.charge_fet, fets.precharge_fet}, 2'h2);
    endtask
    task automatic t_predsg;
        apb(1'b1, `BFS_PDT_ADDR, 32'h5);
        apb(1'b1, `BFS_CTRL_ADDR, 32'h34);
        for (n = 0; n < 20 && fets.predischarge_fet !== 1'b1; n++) cyc(1);
        chk("predischarge_fet first", {fets.discharge_fet, fets.predischarge_fet}, 2'h1);
        k = 0;
        for (n = 0; n < 60 && fets.discharge_fet !== 1'b1; n++) begin
            cyc(1);
            if (fets.discharge_fet !== 1'b1 && fets.predischarge_fet !== 1'b1) k++;
        end
        chk("gap", 0, k);
        chk("hold", n >= 4, 1'b1);
        cyc(5);
        chk("dsg", {fets.discharge_fet, fets.predischarge_fet}, 2'h2);
    endtask
    task automatic t_modes;
        apb(1'b1, `BFS_CTRL_ADDR, 32'h32);
        @(posedge pclk);
        pf <= 1'b1;
        cyc(10);
        chk("manual", 1'b1, fets.discharge_fet);
        apb(1'b1, `BFS_CTRL_ADDR, 32'h30);
        cyc(10);
        chk("standalone", 1'b0, fets.discharge_fet);
        apb(1'b1, `BFS_CTRL_ADDR, 32'h31);
        cyc(10);
        chk("autonomous", 1'b0, fets.discharge_fet);
        @(posedge pclk);
        pf <= 1'b0;
    endtask
    task automatic t_ld;
        apb(1'b1, `BFS_LDT_ADDR, 32'h00140202);
        apb(1'b1, `BFS_CTRL_ADDR, 32'h08);
        @(posedge pclk);
        scd <= 1'b1;
        @(posedge pclk);
        scd <= 1'b0;
        ld_open <= 1'b1;
        open_mv <= `BFS_LD_MV_4V;
        k = 0;
        for (n = 0; n < 200; n++) begin
            cyc(1);
            if (ld_current_en === 1'b1) k++;
        end
        chk("at 4V", 1'b1, fault_flag);
        chk("timeout", {fault_flag, fets.discharge_fet}, 2'h2);
        chk("pulsed", (k > 20 && k < 180), 1'b1);
        apb(1'b0, `BFS_STAT_ADDR, 32'h0);
        chk("status", 32'h00000810, rd);
        k = 0;
        for (n = 0; n < 40; n++) begin
            cyc(1);
            if (ld_current_en !== 1'b0) k++;
        end
        chk("stopped", 0, k);
        @(posedge pclk);
        open_mv <= 16'h0fa1;
        apb(1'b1, `BFS_CTRL_ADDR, 32'h88);
        @(posedge pclk);
        scd <= 1'b1;
        @(posedge pclk);
        scd <= 1'b0;
        for (n = 0; n < 100 && fault_flag !== 1'b0; n++) cyc(1);
        chk("recover", 1'b0, fault_flag);
    endtask
    task automatic t_pin;
        apb(1'b1, `BFS_CTRL_ADDR, 32'h50);
        cyc(20);
        chk("link on", {swl_sel, fets.charge_fet}, 2'h3);
        @(posedge pclk);
        rs_pin <= 1'b1;
        cyc(3);
        chk("pin reset", {swl_sel, fets.charge_fet}, 2'h1);
        chk("no shut", 1'b0, shutdown);
        cyc(110);
        chk("shutdown", 1'b1, shutdown);
        @(posedge pclk);
        rs_pin <= 1'b0;
        apb(1'b1, `BFS_LDO_ADDR, 32'h0000000c);
        cyc(1);
        chk("pd shut", {ldo_en, pd_weak, pd_strong}, 3'h2);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, otp_done, rs_pin, cblk, dblk} = 8'h0;
        {scd, ocd, pf, ld_open} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        cell_mv = 16'h0dac;
        open_mv = 16'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        t_boot();
        t_ldo();
        t_mux();
        t_prechg();
        t_predsg();
        t_modes();
        t_ld();
        t_pin();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire

/* verilog/bfs_ctrl.sv */
`include "bfs_regs.svh"
`default_nettype none
module bfs_ctrl #(
    parameter int CLK_HZ = 100000000,
    parameter int SHUT_HOLD_CYC = 100000000,
    parameter int OTP_CYC = 8,
    parameter int TICK_CYC = 100000
) (
    input wire logic pclk, // 100 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire bfs_pkg::bfs_meas_t meas, // Measurement results
    input wire logic reset_shutdown_pin, // Reset/shutdown pin, active high
    input wire logic charge_block_pin, // Blocks charge path
    input wire logic discharge_block_pin, // Blocks discharge path
    input wire logic otp_done, // OTP read finished
    output bfs_pkg::bfs_fets_t fets, // FET gate requests
    output logic ld_current_en, // Load-detect current source
    output logic fault_flag, // Latched discharge fault
    output logic ldo_en, // user_ldo enable
    output logic prereg_en, // preregulator enable
    output logic [2:0] ldo_sel, // user_ldo level code
    output logic pd_weak, // 10M discharge path
    output logic pd_strong, // 2.5k discharge path
    output logic swl_sel, // Single-wire link selected
    output logic [4:0] mux_sel, // ADC input selector
    output logic vref_b_path, // Thermistor reference path
    output logic shutdown, // Shutdown mode request
    output logic boot_done // Config load complete
);
    import bfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_q, ldo_q, mux_q, thr_q, ldt_q, pdt_q;
    logic [31:0] hold_cnt_q;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic soft_rst;
    logic wr;
    bfs_mode_t mode;
    logic [3:0] otp_cnt_q;
    logic boot_q;

    assign wr = psel && penable && pwrite && boot_q;
    assign mode = bfs_mode_t'(ctrl_q[`BFS_CTRL_MODE_LO +: 2]);

    // Held high resets CTRL, LDO and MUX; FET and fault state survive
    assign soft_rst = reset_shutdown_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_q <= 32'h0;
            shutdown <= 1'b0;
        end else if (!reset_shutdown_pin) begin
            hold_cnt_q <= 32'h0;
        end else if (hold_cnt_q >= SHUT_HOLD_CYC - 1) begin
            shutdown <= 1'b1;
        end else begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
        end
    end

    // Boot wait: registers hold OTP-loaded values before host access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            otp_cnt_q <= 4'h0;
            boot_q <= 1'b0;
        end else if (!boot_q && otp_done) begin
            if (otp_cnt_q >= 4'(OTP_CYC - 1)) begin
                boot_q <= 1'b1;
            end else begin
                otp_cnt_q <= otp_cnt_q + 4'h1;
            end
        end
    end
    assign boot_done = boot_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0;
        end else if (tick) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end
    assign tick = (tick_cnt_q == TICK_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h0; // I2C after reset
            ldo_q <= `BFS_LDO_RST;
            mux_q <= 32'h0;
            thr_q <= `BFS_THR_RST;
            ldt_q <= `BFS_LDT_RST;
            pdt_q <= `BFS_PDT_RST;
        end else if (soft_rst) begin
            // FET request bits survive the pin reset so the FETs keep their state
            ctrl_q <= ctrl_q & ((32'h1 << `BFS_CTRL_CHG_REQ) | (32'h1 << `BFS_CTRL_DSG_REQ)
                | (32'h1 << `BFS_CTRL_PREDISCHARGE_FET_EN));
            ldo_q <= `BFS_LDO_RST;
            mux_q <= 32'h0;
        end else if (wr) begin
            case (paddr)
                `BFS_CTRL_ADDR: ctrl_q <= {24'h0, 1'b0, pwdata[6:0]};
                `BFS_LDO_ADDR: begin
                    // Five levels only; other codes are ignored
                    ldo_q[1:0] <= pwdata[1:0];
                    if (pwdata[`BFS_LDO_SEL_LO +: 3] <= `BFS_LDO_SEL_MAX) begin
                        ldo_q[`BFS_LDO_SEL_LO +: 3] <= pwdata[`BFS_LDO_SEL_LO +: 3];
                    end
                end
                `BFS_MUX_ADDR: begin
                    if (pwdata[4:0] <= `BFS_MUX_MAX) begin
                        mux_q <= {27'h0, pwdata[4:0]};
                    end
                end
                `BFS_THR_ADDR: thr_q <= pwdata;
                `BFS_LDT_ADDR: ldt_q <= pwdata;
                `BFS_PDT_ADDR: pdt_q <= pwdata;
                default: ;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr > `BFS_PDT_ADDR || paddr[1:0] != 2'h0);
    assign ldo_en = ldo_q[`BFS_LDO_EN];
    assign prereg_en = ldo_q[`BFS_PREREG_EN];
    assign ldo_sel = ldo_q[`BFS_LDO_SEL_LO +: 3];
    assign swl_sel = ctrl_q[`BFS_CTRL_SWL_SEL];
    assign mux_sel = mux_q[4:0];
    // Codes 6..8 are the thermistor pins, the only inputs not on reference a
    assign vref_b_path = (mux_q[4:0] >= 5'h06) && (mux_q[4:0] <= 5'h08);
    assign pd_weak = !ldo_en && shutdown;
    assign pd_strong = !ldo_en && !shutdown;

    ////////////////////////////////////////////////////////////////////////
    // Fault latch and load-detect recovery
    bfs_ld_t ld_q;
    logic [15:0] ld_cnt_q;
    logic [15:0] ld_tmo_q;
    logic fault_q;
    logic det_quit_q;
    logic fault_clr;
    logic ld_ok;

    assign ld_ok = meas.load_detect_mv > `BFS_LD_MV_4V;
    assign fault_clr = (ld_q == BFS_L_ON) && ld_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
        end else if (meas.scd_latch || meas.ocd_latch) begin
            fault_q <= 1'b1; // Set wins over clear
        end else if (fault_clr) begin
            fault_q <= 1'b0;
        end else if (wr && paddr == `BFS_CTRL_ADDR && pwdata[`BFS_CTRL_FCLR]) begin
            fault_q <= 1'b0;
        end
    end
    assign fault_flag = fault_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_q <= BFS_L_IDLE;
            ld_cnt_q <= 16'h0;
            ld_tmo_q <= 16'h0;
            det_quit_q <= 1'b0;
        end else begin
            if (!fault_q) begin
                det_quit_q <= 1'b0;
            end
            case (ld_q)
                BFS_L_IDLE: begin
                    ld_cnt_q <= 16'h0;
                    ld_tmo_q <= 16'h0;
                    if (fault_q && !fets.discharge_fet && ctrl_q[`BFS_CTRL_LD_EN]
                        && !det_quit_q) begin
                        ld_q <= BFS_L_ON;
                    end
                end
                BFS_L_ON: begin
                    if (fault_clr || !fault_q) begin
                        ld_q <= BFS_L_IDLE;
                    end else if (tick) begin
                        ld_cnt_q <= ld_cnt_q + 16'h1;
                        if (ld_cnt_q >= {8'h0, ldt_q[7:0]}) begin
                            ld_cnt_q <= 16'h0;
                            ld_q <= BFS_L_OFF;
                        end
                    end
                end
                BFS_L_OFF: begin
                    if (!fault_q) begin
                        ld_q <= BFS_L_IDLE;
                    end else if (tick) begin
                        ld_cnt_q <= ld_cnt_q + 16'h1;
                        ld_tmo_q <= ld_tmo_q + 16'h1;
                        if (ld_tmo_q >= ldt_q[31:16]) begin
                            // Give up: fault stays latched
                            ld_q <= BFS_L_IDLE;
                            det_quit_q <= 1'b1;
                        end else if (ld_cnt_q >= {8'h0, ldt_q[15:8]}) begin
                            ld_cnt_q <= 16'h0;
                            ld_q <= BFS_L_ON;
                        end
                    end
                end
                default: ld_q <= BFS_L_IDLE;
            endcase
        end
    end
    // After a timeout the source stays off until the fault is cleared another way
    assign ld_current_en = (ld_q == BFS_L_ON);

    ////////////////////////////////////////////////////////////////////////
    // FET control
    logic dsg_allow, chg_allow, prechg;
    logic prot_off;
    bfs_dsg_t dsg_q;
    logic [15:0] pd_cnt_q;
    logic chg_q, precharge_fet_q;

    // In manual mode protection only flags; host drops the request bits
    assign prot_off = (mode != BFS_MANUAL) && meas.prot_fault;
    assign dsg_allow = ctrl_q[`BFS_CTRL_DSG_REQ] && !discharge_block_pin && !prot_off
        && !fault_q && !shutdown;
    assign chg_allow = ctrl_q[`BFS_CTRL_CHG_REQ] && !charge_block_pin && !prot_off
        && !shutdown;

    // Hysteresis between entry threshold and recovery level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prechg <= 1'b0;
        end else if (meas.min_cell_mv < thr_q[15:0]) begin
            prechg <= 1'b1;
        end else if (meas.min_cell_mv >= thr_q[31:16]) begin
            prechg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_q <= 1'b0;
            precharge_fet_q <= 1'b0;
        end else begin
            chg_q <= chg_allow && !prechg;
            precharge_fet_q <= chg_allow && prechg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsg_q <= BFS_D_OFF;
            pd_cnt_q <= 16'h0;
        end else begin
            case (dsg_q)
                BFS_D_OFF: begin
                    pd_cnt_q <= 16'h0;
                    if (dsg_allow) begin
                        dsg_q <= ctrl_q[`BFS_CTRL_PREDISCHARGE_FET_EN] ? BFS_D_PRE : BFS_D_ON;
                    end
                end
                BFS_D_PRE: begin
                    if (!dsg_allow) begin
                        dsg_q <= BFS_D_OFF;
                    end else if (pd_cnt_q >= pdt_q[15:0]) begin
                        dsg_q <= BFS_D_ON;
                    end else begin
                        pd_cnt_q <= pd_cnt_q + 16'h1;
                    end
                end
                BFS_D_ON: begin
                    if (!dsg_allow) begin
                        dsg_q <= BFS_D_OFF;
                    end
                end
                default: dsg_q <= BFS_D_OFF;
            endcase
        end
    end

    // Predischarge held through the first ON cycle so both never drop together
    logic predischarge_fet_tail_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            predischarge_fet_tail_q <= 1'b0;
        end else begin
            predischarge_fet_tail_q <= (dsg_q == BFS_D_PRE) && dsg_allow;
        end
    end

    assign fets.charge_fet = chg_q;
    assign fets.precharge_fet = precharge_fet_q;
    assign fets.discharge_fet = (dsg_q == BFS_D_ON);
    assign fets.predischarge_fet = (dsg_q == BFS_D_PRE) || (predischarge_fet_tail_q && dsg_q == BFS_D_ON);

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        prdata = 32'h0;
        case (paddr)
            `BFS_CTRL_ADDR: prdata = ctrl_q;
            `BFS_LDO_ADDR: prdata = ldo_q;
            `BFS_MUX_ADDR: prdata = mux_q;
            `BFS_THR_ADDR: prdata = thr_q;
            `BFS_LDT_ADDR: prdata = ldt_q;
            `BFS_PDT_ADDR: prdata = pdt_q;
            `BFS_STAT_ADDR: prdata = {20'h0, boot_q, shutdown, prechg, ld_q, dsg_q,
                fault_q, fets};
            default: prdata = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    property p_reset_ldo;
        @(posedge pclk) disable iff (!presetn)
        $rose(boot_q) |-> ldo_en && prereg_en && (ldo_sel == `BFS_LDO_SEL_33);
    endproperty
    a_reset_ldo: assert property (p_reset_ldo) else $error("ldo defaults wrong");
    property p_ld_clear;
        @(posedge pclk) disable iff (!presetn)
        (fault_clr && !meas.scd_latch && !meas.ocd_latch) |=> !fault_q;
    endproperty
    a_ld_clear: assert property (p_ld_clear) else $error("fault not cleared");
    property p_ld_only_hi;
        @(posedge pclk) disable iff (!presetn)
        $fell(fault_q) && !$past(wr) |-> $past(ld_ok);
    endproperty
    a_ld_only_hi: assert property (p_ld_only_hi) else $error("bad clear");
    property p_no_dsg_fault;
        @(posedge pclk) disable iff (!presetn)
        fault_q |=> !fets.discharge_fet || !$past(fault_q, 1);
    endproperty
    a_no_dsg_fault: assert property (p_no_dsg_fault) else $error("dsg on in fault");
    sequence s_pre;
        dsg_q == BFS_D_PRE;
    endsequence
    property p_handover;
        @(posedge pclk) disable iff (!presetn)
        s_pre ##1 (dsg_q == BFS_D_ON) |-> fets.predischarge_fet;
    endproperty
    a_handover: assert property (p_handover) else $error("gap in handover");
    property p_predischarge_fet_first;
        @(posedge pclk) disable iff (!presetn)
        $rose(fets.discharge_fet) && ctrl_q[`BFS_CTRL_PREDISCHARGE_FET_EN] |-> $past(fets.predischarge_fet);
    endproperty
    a_predischarge_fet_first: assert property (p_predischarge_fet_first) else $error("no predischarge");
    property p_prechg;
        @(posedge pclk) disable iff (!presetn)
        prechg |=> !fets.charge_fet;
    endproperty
    a_prechg: assert property (p_prechg) else $error("charge fet in precharge");
    property p_ldo_sel;
        @(posedge pclk) disable iff (!presetn)
        ldo_sel <= `BFS_LDO_SEL_MAX;
    endproperty
    a_ldo_sel: assert property (p_ldo_sel) else $error("bad ldo level");
    property p_pd;
        @(posedge pclk) disable iff (!presetn)
        !(pd_weak && pd_strong) && (!ldo_en || (!pd_weak && !pd_strong));
    endproperty
    a_pd: assert property (p_pd) else $error("discharge path wrong");
    property p_manual;
        @(posedge pclk) disable iff (!presetn)
        (mode == BFS_MANUAL) && fets.discharge_fet && ctrl_q[`BFS_CTRL_DSG_REQ]
            && !discharge_block_pin && !fault_q && !shutdown |=> fets.discharge_fet;
    endproperty
    a_manual: assert property (p_manual) else $error("manual mode acted");
    // Length of the current on-phase, bounded by the programmed on-time
    logic [31:0] src_run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_run_q <= 32'h0;
        end else begin
            src_run_q <= ld_current_en ? src_run_q + 32'h1 : 32'h0;
        end
    end
    property p_ld_period;
        @(posedge pclk) disable iff (!presetn)
        src_run_q <= ({24'h0, ldt_q[7:0]} + 32'h1) * TICK_CYC;
    endproperty
    a_ld_period: assert property (p_ld_period) else $error("source on too long");
endmodule // bfs_ctrl
`default_nettype wire

/* verilog/bfs_pkg.sv */
`default_nettype none
package bfs_pkg;
    typedef enum logic [1:0] {
        BFS_STANDALONE = 2'b00,
        BFS_AUTONOMOUS = 2'b01,
        BFS_MANUAL = 2'b10
    } bfs_mode_t;
    typedef enum logic [1:0] {
        BFS_D_OFF = 2'b00,
        BFS_D_PRE = 2'b01,
        BFS_D_ON = 2'b10
    } bfs_dsg_t;
    typedef enum logic [1:0] {
        BFS_L_IDLE = 2'b00,
        BFS_L_ON = 2'b01,
        BFS_L_OFF = 2'b10
    } bfs_ld_t;
    typedef struct packed {
        logic charge_fet;
        logic precharge_fet;
        logic discharge_fet;
        logic predischarge_fet;
    } bfs_fets_t;
    typedef struct packed {
        logic [15:0] min_cell_mv;
        logic [15:0] load_detect_mv;
        logic scd_latch;
        logic ocd_latch;
        logic prot_fault;
        logic prot_recover;
    } bfs_meas_t;
endpackage
`default_nettype wire

/* verilog/bfs_regs.svh */
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH
// APB register byte addresses
`define BFS_CTRL_ADDR 12'h000
`define BFS_LDO_ADDR 12'h004
`define BFS_MUX_ADDR 12'h008
`define BFS_THR_ADDR 12'h00c
`define BFS_LDT_ADDR 12'h010
`define BFS_STAT_ADDR 12'h014
`define BFS_PDT_ADDR 12'h018
// CTRL fields
`define BFS_CTRL_MODE_LO 0
`define BFS_CTRL_PREDISCHARGE_FET_EN 2
`define BFS_CTRL_LD_EN 3
`define BFS_CTRL_CHG_REQ 4
`define BFS_CTRL_DSG_REQ 5
`define BFS_CTRL_SWL_SEL 6
`define BFS_CTRL_FCLR 7
// LDO fields and reset values
`define BFS_LDO_EN 0
`define BFS_PREREG_EN 1
`define BFS_LDO_SEL_LO 2
`define BFS_LDO_RST 32'h0000000f
`define BFS_LDO_SEL_33 3'h3
`define BFS_LDO_SEL_MAX 3'h4
// Thresholds in mV, load-detect and predischarge timing defaults, mux code limit
`define BFS_LD_MV_4V 16'h0fa0
`define BFS_THR_RST 32'h0c1c0a8c
`define BFS_LDT_RST 32'h00640a0a
`define BFS_PDT_RST 32'h00000064
`define BFS_MUX_MAX 5'h0b
`endif
